// ### hdl/lre_pkg.sv
// Purpose: constants of the IF-THEN logic rule engine
// Assumes: 32-bit AHB-Lite register access, one 25 MHz clock
// Notes: rule configuration words are packed as the field positions below
// Function
// - The engine holds and evaluates at most sixteen rules, each known by its index.
// - Each rule has four condition slots and four action slots, each separately enabled.
// - A bank of sixteen internal flags exists apart from the physical channels.
// - Every internal flag is one boolean bit.
// - Flags serve as condition inputs and as action targets, so rules can cascade.
// - Flag tests are ON, OFF, ON-to-OFF, OFF-to-ON; analog tests are =,>,<,>=,<=; actions set/clear a flag or request a trap.
// - The enabled conditions of a rule are joined by one per-rule OR or AND selector.
// - Every rule takes its clock in the scan, but only enabled rules can fire; disabled rules never act.
// - While the run bit is set, enabled rules are evaluated once per sixteen-clock pass and act whenever their condition holds.
// - On a save request made while no save is busy, the whole rule configuration is written to flash; hosts should batch saves.
`default_nettype none
package lre_pkg;
    localparam int NUM_RULES = 16;
    localparam int NUM_SLOTS = 4;
    localparam int NUM_FLAGS = 16;
    localparam int SMP_W = 16;
    localparam int WORDS_PER_RULE = 9;
    localparam int IRQ_W = 3;
    localparam int RC_W = 10;
    localparam int COND_W = 24;
    localparam int ACT_W = 6;
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_FLAGS = 12'h008;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h00c;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
    localparam logic [11:0] OFS_TRAP_SRV = 12'h014;
    localparam logic [11:0] OFS_RULE_BASE = 12'h100;
    localparam logic [11:0] RULE_SPAN = 12'h400;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SAVE = 1;
    localparam int IRQ_PASS = 0;
    localparam int IRQ_TRAP = 1;
    localparam int IRQ_SAVE = 2;
    localparam int RC_EN = 0;
    localparam int RC_AND = 1;
    localparam int RC_CEN = 2;
    localparam int RC_AEN = 6;
    localparam int COND_THR = 0;
    localparam int COND_OP = 16;
    localparam int COND_SRC = 19;
    localparam int COND_ANALOG = 23;
    localparam int ACT_IDX = 0;
    localparam int ACT_VAL = 4;
    localparam int ACT_TRAP = 5;
    localparam logic [2:0] FOP_ON = 3'h0;
    localparam logic [2:0] FOP_OFF = 3'h1;
    localparam logic [2:0] FOP_FALL = 3'h2;
    localparam logic [2:0] FOP_RISE = 3'h3;
    localparam logic [2:0] AOP_EQ = 3'h0;
    localparam logic [2:0] AOP_GT = 3'h1;
    localparam logic [2:0] AOP_LT = 3'h2;
    localparam logic [2:0] AOP_GE = 3'h3;
    localparam logic [2:0] AOP_LE = 3'h4;
    localparam logic [31:0] TRAP_SRV_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
endpackage : lre_pkg
`default_nettype wire

// ### hdl/lre_cond_eval.sv
// Purpose: evaluates one condition slot of a rule
// Assumes: analog samples are signed and come from logic on sys_clk
// Notes: purely combinational
`default_nettype none
module lre_cond_eval #(
    parameter int NUM_CH = 8
) (
    input wire logic [lre_pkg::COND_W-1:0] cond_word,
    input wire logic [lre_pkg::NUM_FLAGS-1:0] flags_now,
    input wire logic [lre_pkg::NUM_FLAGS-1:0] flags_prev,
    input wire logic [NUM_CH*lre_pkg::SMP_W-1:0] analog_input_channel,
    output logic hit
);
    import lre_pkg::*;
    logic [2:0] op;
    logic [3:0] src;
    logic signed [SMP_W-1:0] thr;
    logic signed [SMP_W-1:0] smp;
    logic now_b;
    logic prev_b;
    always_comb begin
        op = cond_word[COND_OP +: 3];
        src = cond_word[COND_SRC +: 4];
        thr = cond_word[COND_THR +: SMP_W];
        now_b = flags_now[src];
        prev_b = flags_prev[src];
        smp = '0;
        hit = 1'b0;
        if (cond_word[COND_ANALOG]) begin
            // Channels beyond the fitted count never match
            if (32'(src) < NUM_CH) begin
                smp = analog_input_channel[32'(src)*SMP_W +: SMP_W];
                case (op)
                    AOP_EQ: hit = (smp == thr);
                    AOP_GT: hit = (smp > thr);
                    AOP_LT: hit = (smp < thr);
                    AOP_GE: hit = (smp >= thr);
                    AOP_LE: hit = (smp <= thr);
                    default: hit = 1'b0;
                endcase
            end
        end else begin
            case (op)
                FOP_ON: hit = now_b;
                FOP_OFF: hit = !now_b;
                FOP_FALL: hit = prev_b && !now_b;
                FOP_RISE: hit = !prev_b && now_b;
                default: hit = 1'b0;
            endcase
        end
    end
endmodule : lre_cond_eval
`default_nettype wire

// ### hdl/lre_cfg_save.sv
// Purpose: streams the whole rule configuration to the flash controller
// Assumes: flash side holds flash_ready low while it cannot take a word
// Notes: address is {rule, word}; words 0..8 of every rule are sent
`default_nettype none
module lre_cfg_save (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic start,
    output logic busy,
    output logic done,
    output logic [3:0] rd_rule,
    output logic [3:0] rd_word,
    input wire logic [31:0] rd_data,
    output logic flash_valid,
    output logic [7:0] flash_addr,
    output logic [31:0] flash_data,
    input wire logic flash_ready
);
    import lre_pkg::*;
    typedef enum logic {LRE_SV_IDLE, LRE_SV_SEND} lre_sv_t;
    lre_sv_t state_ff, nxt_state;
    logic [3:0] rule_ff, nxt_rule;
    logic [3:0] word_ff, nxt_word;
    logic done_ff, nxt_done;
    logic last;
    always_comb begin
        nxt_state = state_ff;
        nxt_rule = rule_ff;
        nxt_word = word_ff;
        nxt_done = 1'b0;
        last = (rule_ff == 4'(NUM_RULES - 1)) && (word_ff == 4'(WORDS_PER_RULE - 1));
        case (state_ff)
            LRE_SV_IDLE: begin
                if (start) begin
                    nxt_state = LRE_SV_SEND;
                    nxt_rule = 4'h0;
                    nxt_word = 4'h0;
                end
            end
            LRE_SV_SEND: begin
                if (flash_ready) begin
                    if (last) begin
                        nxt_state = LRE_SV_IDLE;
                        nxt_done = 1'b1;
                    end else if (word_ff == 4'(WORDS_PER_RULE - 1)) begin
                        nxt_word = 4'h0;
                        nxt_rule = rule_ff + 4'h1;
                    end else begin
                        nxt_word = word_ff + 4'h1;
                    end
                end
            end
            default: nxt_state = LRE_SV_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_ff <= LRE_SV_IDLE;
            rule_ff <= 4'h0;
            word_ff <= 4'h0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rule_ff <= nxt_rule;
            word_ff <= nxt_word;
            done_ff <= nxt_done;
        end
    end
    // Data is read live from the store; editing rules mid-save yields a mixed image
    assign busy = (state_ff == LRE_SV_SEND);
    assign done = done_ff;
    assign rd_rule = rule_ff;
    assign rd_word = word_ff;
    assign flash_valid = busy;
    assign flash_addr = {rule_ff, word_ff};
    assign flash_data = rd_data;
    save_busy_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state_ff == LRE_SV_IDLE && start) |=> flash_valid && flash_addr == 8'h00)
        else $error("save did not begin at word zero");
endmodule : lre_cfg_save
`default_nettype wire

// ### hdl/lre_engine.sv
// Purpose: IF-THEN rule engine with AHB-Lite register access
// Assumes: analog samples and flash handshake are on sys_clk
// Notes: one rule is evaluated per clock, a pass takes sixteen clocks
`default_nettype none
module lre_engine #(
    parameter int NUM_CH = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [NUM_CH*lre_pkg::SMP_W-1:0] analog_input_channel,
    output logic [lre_pkg::NUM_FLAGS-1:0] flags_out,
    output logic trap_req,
    output logic [3:0] trap_rule,
    output logic [31:0] trap_server_addr,
    output logic flash_valid,
    output logic [7:0] flash_addr,
    output logic [31:0] flash_data,
    input wire logic flash_ready,
    output logic irq
);
    import lre_pkg::*;
    // The source field is four bits wide, so more channels cannot be addressed
    if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_ch
        $error("NUM_CH must be 1..16");
    end

    // Rule store
    logic [RC_W-1:0] rc_ff [NUM_RULES];
    logic [RC_W-1:0] nxt_rc [NUM_RULES];
    logic [COND_W-1:0] cond_ff [NUM_RULES][NUM_SLOTS];
    logic [COND_W-1:0] nxt_cond [NUM_RULES][NUM_SLOTS];
    logic [ACT_W-1:0] act_ff [NUM_RULES][NUM_SLOTS];
    logic [ACT_W-1:0] nxt_act [NUM_RULES][NUM_SLOTS];
    // Control and status
    logic run_ff, nxt_run;
    logic [31:0] srv_ff, nxt_srv;
    logic [IRQ_W-1:0] ist_ff, nxt_ist;
    logic [IRQ_W-1:0] imask_ff, nxt_imask;
    logic [NUM_FLAGS-1:0] flag_ff, nxt_flag;
    logic [NUM_FLAGS-1:0] hist_ff [NUM_RULES];
    logic [NUM_FLAGS-1:0] nxt_hist [NUM_RULES];
    logic [3:0] idx_ff, nxt_idx;
    logic trap_ff, nxt_trap;
    logic [3:0] trule_ff, nxt_trule;
    // Bus state
    logic a_wr_ff, nxt_a_wr;
    logic [11:0] a_addr_ff, nxt_a_addr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic save_start;
    logic save_busy;
    logic save_done;
    logic [3:0] sv_rule;
    logic [3:0] sv_word;
    logic [31:0] sv_data;
    // Evaluation of the current rule
    logic [NUM_SLOTS-1:0] hit;
    logic [NUM_SLOTS-1:0] cen;
    logic [NUM_SLOTS-1:0] aen;
    logic cur_en;
    logic cur_and;
    logic fire;
    logic pass_end;
    logic any_trap;

    function automatic logic [31:0] cfg_word(input logic [3:0] r, input logic [3:0] w);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (w == 4'h0) begin
            v[RC_W-1:0] = rc_ff[r];
        end else if (w <= 4'(NUM_SLOTS)) begin
            v[COND_W-1:0] = cond_ff[r][2'(w - 4'h1)];
        end else if (w <= 4'(2 * NUM_SLOTS)) begin
            v[ACT_W-1:0] = act_ff[r][2'(w - 4'h5)];
        end
        return v;
    endfunction : cfg_word

    assign cur_en = rc_ff[idx_ff][RC_EN];
    assign cur_and = rc_ff[idx_ff][RC_AND];
    assign cen = rc_ff[idx_ff][RC_CEN +: NUM_SLOTS];
    assign aen = rc_ff[idx_ff][RC_AEN +: NUM_SLOTS];
    assign pass_end = run_ff && (idx_ff == 4'(NUM_RULES - 1));

    genvar s;
    generate
        for (s = 0; s < NUM_SLOTS; s++) begin : g_cond
            lre_cond_eval #(.NUM_CH(NUM_CH)) u_cond (
                .cond_word(cond_ff[idx_ff][s]),
                .flags_now(flag_ff),
                .flags_prev(hist_ff[idx_ff]),
                .analog_input_channel(analog_input_channel),
                .hit(hit[s])
            );
        end
    endgenerate

    // A rule with no enabled condition never fires
    always_comb begin
        fire = 1'b0;
        if (run_ff && cur_en && (cen != '0)) begin
            if (cur_and) begin
                fire = &(hit | ~cen);
            end else begin
                fire = |(hit & cen);
            end
        end
        any_trap = 1'b0;
        for (int k = 0; k < NUM_SLOTS; k++) begin
            if (aen[k] && act_ff[idx_ff][k][ACT_TRAP]) begin
                any_trap = 1'b1;
            end
        end
    end

    lre_cfg_save u_save (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .start(save_start),
        .busy(save_busy),
        .done(save_done),
        .rd_rule(sv_rule),
        .rd_word(sv_word),
        .rd_data(sv_data),
        .flash_valid(flash_valid),
        .flash_addr(flash_addr),
        .flash_data(flash_data),
        .flash_ready(flash_ready)
    );
    // A continuous assignment would not wake on store writes read inside the function
    always_comb begin
        sv_data = cfg_word(sv_rule, sv_word);
    end

    always_comb begin
        logic [11:0] rofs;
        logic [11:0] dofs;
        logic in_rules;
        logic d_in_rules;
        logic wr;
        rofs = haddr[11:0] - OFS_RULE_BASE;
        dofs = a_addr_ff - OFS_RULE_BASE;
        in_rules = (haddr[31:12] == 20'h00000) && (haddr[11:0] >= OFS_RULE_BASE) && (rofs < RULE_SPAN);
        d_in_rules = (a_addr_ff >= OFS_RULE_BASE) && (dofs < RULE_SPAN) && (dofs[5:2] < 4'(WORDS_PER_RULE));
        wr = a_wr_ff;
        nxt_rc = rc_ff;
        nxt_cond = cond_ff;
        nxt_act = act_ff;
        nxt_run = run_ff;
        nxt_srv = srv_ff;
        nxt_imask = imask_ff;
        nxt_ist = ist_ff;
        nxt_flag = flag_ff;
        nxt_hist = hist_ff;
        nxt_idx = idx_ff;
        nxt_trap = 1'b0;
        nxt_trule = trule_ff;
        save_start = 1'b0;
        // Address phase
        nxt_a_wr = 1'b0;
        nxt_a_addr = a_addr_ff;
        nxt_rdata = rdata_ff;
        if (hsel && hready && htrans[1]) begin
            nxt_a_wr = hwrite;
            nxt_a_addr = haddr[31:12] == 20'h00000 ? {haddr[11:2], 2'b00} : 12'hffc;
            if (!hwrite) begin
                nxt_rdata = 32'h0000_0000;
                if (in_rules) begin
                    nxt_rdata = cfg_word(rofs[9:6], rofs[5:2]);
                end else if (haddr[31:12] == 20'h00000) begin
                    case ({haddr[11:2], 2'b00})
                        OFS_CTRL: nxt_rdata[CTRL_RUN] = run_ff;
                        OFS_STATUS: nxt_rdata = {11'h000, save_busy, idx_ff, flag_ff};
                        OFS_FLAGS: nxt_rdata[NUM_FLAGS-1:0] = flag_ff;
                        OFS_IRQ_STAT: nxt_rdata[IRQ_W-1:0] = ist_ff;
                        OFS_IRQ_MASK: nxt_rdata[IRQ_W-1:0] = imask_ff;
                        OFS_TRAP_SRV: nxt_rdata = srv_ff;
                        default: nxt_rdata = 32'h0000_0000;
                    endcase
                end
            end
        end
        // Data phase writes
        if (wr) begin
            if (d_in_rules) begin
                if (dofs[5:2] == 4'h0) begin
                    nxt_rc[dofs[9:6]] = hwdata[RC_W-1:0];
                end else if (dofs[5:2] <= 4'(NUM_SLOTS)) begin
                    nxt_cond[dofs[9:6]][2'(dofs[5:2] - 4'h1)] = hwdata[COND_W-1:0];
                end else begin
                    nxt_act[dofs[9:6]][2'(dofs[5:2] - 4'h5)] = hwdata[ACT_W-1:0];
                end
            end else begin
                case (a_addr_ff)
                    OFS_CTRL: begin
                        nxt_run = hwdata[CTRL_RUN];
                        save_start = hwdata[CTRL_SAVE] && !save_busy;
                    end
                    OFS_FLAGS: nxt_flag = hwdata[NUM_FLAGS-1:0];
                    OFS_IRQ_STAT: nxt_ist = ist_ff & ~hwdata[IRQ_W-1:0];
                    OFS_IRQ_MASK: nxt_imask = hwdata[IRQ_W-1:0];
                    OFS_TRAP_SRV: nxt_srv = hwdata;
                    default: nxt_a_wr = nxt_a_wr;
                endcase
            end
        end
        // Scan: engine writes override a software flag write in the same cycle
        if (run_ff) begin
            nxt_idx = idx_ff + 4'h1;
            // Each rule compares with the flags it saw one pass earlier, so no edge is seen twice; a flag that flips back within one pass is missed
            nxt_hist[idx_ff] = flag_ff;
            if (fire) begin
                for (int k = 0; k < NUM_SLOTS; k++) begin
                    if (aen[k] && !act_ff[idx_ff][k][ACT_TRAP]) begin
                        nxt_flag[act_ff[idx_ff][k][ACT_IDX +: 4]] = act_ff[idx_ff][k][ACT_VAL];
                    end
                end
                if (any_trap) begin
                    nxt_trap = 1'b1;
                    nxt_trule = idx_ff;
                end
            end
        end
        // Hardware set wins over a software clear
        if (pass_end) begin
            nxt_ist[IRQ_PASS] = 1'b1;
        end
        if (fire && any_trap) begin
            nxt_ist[IRQ_TRAP] = 1'b1;
        end
        if (save_done) begin
            nxt_ist[IRQ_SAVE] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int r = 0; r < NUM_RULES; r++) begin
                rc_ff[r] <= '0;
                hist_ff[r] <= '0;
                for (int k = 0; k < NUM_SLOTS; k++) begin
                    cond_ff[r][k] <= '0;
                    act_ff[r][k] <= '0;
                end
            end
            run_ff <= 1'b0;
            srv_ff <= TRAP_SRV_RST;
            ist_ff <= '0;
            imask_ff <= IRQ_MASK_RST;
            flag_ff <= '0;
            idx_ff <= 4'h0;
            trap_ff <= 1'b0;
            trule_ff <= 4'h0;
            a_wr_ff <= 1'b0;
            a_addr_ff <= 12'h000;
            rdata_ff <= 32'h0000_0000;
        end else begin
            rc_ff <= nxt_rc;
            cond_ff <= nxt_cond;
            act_ff <= nxt_act;
            run_ff <= nxt_run;
            srv_ff <= nxt_srv;
            ist_ff <= nxt_ist;
            imask_ff <= nxt_imask;
            flag_ff <= nxt_flag;
            hist_ff <= nxt_hist;
            idx_ff <= nxt_idx;
            trap_ff <= nxt_trap;
            trule_ff <= nxt_trule;
            a_wr_ff <= nxt_a_wr;
            a_addr_ff <= nxt_a_addr;
            rdata_ff <= nxt_rdata;
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign flags_out = flag_ff;
    assign trap_req = trap_ff;
    assign trap_rule = trule_ff;
    assign trap_server_addr = srv_ff;
    assign irq = |(ist_ff & imask_ff);

    scan_order_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        run_ff && nxt_run && idx_ff != 4'hf |=> idx_ff == $past(idx_ff) + 4'h1)
        else $error("rules not scanned in ascending order");
    scan_wrap_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        run_ff && idx_ff == 4'hf |=> idx_ff == 4'h0 && ist_ff[IRQ_PASS])
        else $error("pass did not wrap after sixteen rules");
    disabled_rule_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !cur_en |-> !fire ##1 !trap_req)
        else $error("disabled rule acted");
    and_relation_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        run_ff && cur_en && cur_and && cen != 4'h0 |-> fire == ((hit & cen) == cen))
        else $error("AND relation mismatch");
    or_relation_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        run_ff && cur_en && !cur_and |-> fire == ((hit & cen) != 4'h0))
        else $error("OR relation mismatch");
    last_slot_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        fire && aen[3] && !act_ff[idx_ff][3][ACT_TRAP]
        |=> flag_ff[$past(act_ff[idx_ff][3][3:0])] == $past(act_ff[idx_ff][3][ACT_VAL]))
        else $error("flag action not applied");
    trap_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        fire && any_trap |=> trap_req && trap_rule == $past(idx_ff) && ist_ff[IRQ_TRAP])
        else $error("trap request missing");
    continuous_scan_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        run_ff && nxt_run |=> idx_ff != $past(idx_ff))
        else $error("scan stalled while running");
endmodule : lre_engine
`default_nettype wire

// ### bench/lre_flash_model.sv
// Purpose: flash side model that takes the saved rule words
// Assumes: a word is accepted at each edge where valid and ready are both high
// Notes: in slow mode ready drops every third cycle so held requests get exercised
`default_nettype none
module lre_flash_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic flash_valid,
    input wire logic [7:0] flash_addr,
    input wire logic [31:0] flash_data,
    output logic flash_ready,
    output int n_words,
    output logic [7:0] last_addr,
    output logic [31:0] first_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;
    assign flash_ready = !slow || (cyc % 3 != 0);
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (!resetn) begin
            n_words <= 0;
        end else if (flash_valid && flash_ready) begin
            n_words <= n_words + 1;
            last_addr <= flash_addr;
            if (flash_addr == 8'h00) begin
                first_data <= flash_data;
            end
        end
    end
endmodule : lre_flash_model
`default_nettype wire

// ### bench/testbench.sv
// Purpose: self-checking bench of the logic rule engine
// Assumes: zero wait AHB-Lite slave, flash model on the far side
// Notes: analog values are raw counts; thresholds sit on comparison boundaries
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import lre_pkg::*;
    logic sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0, slow = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, trap_server_addr, flash_data, first_data;
    logic [1:0] htrans = 0;
    logic [127:0] ain = 0;
    logic [15:0] flags_out;
    logic hreadyout, hresp, trap_req, flash_valid, flash_ready, irq;
    logic [3:0] trap_rule;
    logic [7:0] flash_addr, last_addr;
    logic [3:0] fsrc [7:14] = '{4'h2, 4'h3, 4'ha, 4'ha, 4'hc, 4'hf, 4'hf, 4'hf};
    logic [2:0] fop [7:14] = '{FOP_ON, FOP_OFF, FOP_FALL, FOP_RISE, FOP_ON, FOP_OFF, FOP_OFF, FOP_OFF};
    logic [31:0] fact [7:14] = '{32'h17, 32'h18, 32'h1b, 32'h1c, 32'h2f, 32'h1d, 32'h19, 32'h09};
    int n_fail = 0, num_checks = 0, n_words, hi;
    always #20 sys_clk = ~sys_clk;
    lre_engine DUT (
        .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .analog_input_channel(ain), .flags_out(flags_out),
        .trap_req(trap_req), .trap_rule(trap_rule), .trap_server_addr(trap_server_addr),
        .flash_valid(flash_valid), .flash_addr(flash_addr), .flash_data(flash_data),
        .flash_ready(flash_ready), .irq(irq)
    );
    lre_flash_model flash (
        .sys_clk(sys_clk), .resetn(resetn), .slow(slow), .flash_valid(flash_valid),
        .flash_addr(flash_addr), .flash_data(flash_data), .flash_ready(flash_ready),
        .n_words(n_words), .last_addr(last_addr), .first_data(first_data)
    );
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cfg(input int r, input int w, input logic [31:0] d);
        ahb(1'b1, {20'h0, OFS_RULE_BASE} + r * 64 + w * 4, d);
    endtask : cfg
    function automatic logic [31:0] rc(input logic a, input logic [3:0] c, input logic [3:0] e);
        return {22'h0, e, c, a, 1'b1};
    endfunction : rc
    function automatic logic [31:0] cnd(input logic an, input logic [3:0] s, input logic [2:0] op, input int t);
        return {8'h0, an, s, op, t[15:0]};
    endfunction : cnd
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    initial begin
        #(40 * 20000);
        n_fail++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        ahb(1'b1, 32'h18, 32'hffff_ffff);
        ahb(1'b1, 32'h124, 32'hffff_ffff);
        foreach (fact[i]) begin
            ahb(1'b0, (i == 7) ? 32'h18 : (i == 8) ? 32'h124 : 32'h4 * (i - 9), 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, hresp}, 32'h0);
        end
        cfg(0, 0, rc(0, 4'h3, 4'h1));
        cfg(0, 1, cnd(1, 0, AOP_GT, 500));
        cfg(0, 2, cnd(1, 1, AOP_GT, 800));
        cfg(0, 5, 32'h10);
        cfg(0, 6, 32'h1e);
        cfg(1, 0, rc(1, 4'h3, 4'h1));
        cfg(1, 1, cnd(1, 0, AOP_LE, 500));
        cfg(1, 2, cnd(1, 1, AOP_LE, 800));
        cfg(1, 5, 32'h00);
        for (int r = 2; r < 15; r++) begin
            cfg(r, 0, (r == 12) ? 32'h44 : rc(0, 4'h1, 4'h1));
            cfg(r, 1, (r < 7) ? cnd(1'b1, 4'h2, 3'(r - 2), 100) : cnd(1'b0, fsrc[r], fop[r], 0));
            cfg(r, 5, (r < 7) ? 32'h10 + r : fact[r]);
        end
        ahb(1'b1, {20'h0, OFS_TRAP_SRV}, 32'h0a0b_0c0d);
        @(negedge sys_clk);
        chk(trap_server_addr, 32'h0a0b_0c0d);
        ahb(1'b1, {20'h0, OFS_IRQ_MASK}, 32'h2);
        ain[15:0] <= 16'd600;
        ain[47:32] <= 16'd100;
        ahb(1'b1, {20'h0, OFS_CTRL}, 32'h1);
        repeat (48) @(posedge sys_clk);
        chk(flags_out & 16'hfdff, 16'h01e5);
        chk(irq, 1'b0);
        hi = 0;
        repeat (32) begin
            @(posedge sys_clk);
            hi += flags_out[9];
        end
        chk(hi, 2);
        ain[15:0] <= 16'd400;
        ain[31:16] <= 16'd800;
        repeat (48) @(posedge sys_clk);
        chk(flags_out[0], 1'b0);
        ain[31:16] <= 16'd801;
        repeat (48) @(posedge sys_clk);
        chk(flags_out[0], 1'b1);
        ahb(1'b1, {20'h0, OFS_FLAGS}, 32'h05e5);
        repeat (48) @(posedge sys_clk);
        chk(flags_out[12], 1'b1);
        chk(trap_rule, 4'hb);
        chk(irq, 1'b1);
        for (hi = 0; hi < 20 && trap_req !== 1'b1; hi++) @(posedge sys_clk);
        chk(trap_req, 1'b1);
        @(posedge sys_clk);
        chk(trap_req, 1'b0);
        ahb(1'b1, {20'h0, OFS_FLAGS}, 32'h11e5);
        repeat (48) @(posedge sys_clk);
        chk(flags_out[11], 1'b1);
        ahb(1'b1, {20'h0, OFS_CTRL}, 32'h0);
        repeat (2) @(posedge sys_clk);
        ahb(1'b0, {20'h0, OFS_IRQ_STAT}, 32'h0);
        chk(rd[1:0], 2'h3);
        ahb(1'b1, {20'h0, OFS_IRQ_STAT}, 32'h7);
        ahb(1'b0, {20'h0, OFS_IRQ_STAT}, 32'h0);
        chk(rd, 32'h0);
        chk(irq, 1'b0);
        ahb(1'b1, {20'h0, OFS_IRQ_MASK}, 32'h4);
        ahb(1'b1, {20'h0, OFS_CTRL}, 32'h2);
        for (hi = 0; hi < 2000 && irq !== 1'b1; hi++) @(posedge sys_clk);
        chk(irq, 1'b1);
        chk(n_words, 144);
        chk(last_addr, 8'hf8);
        chk(first_data, 32'h4d);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
